// file: plc_params.svh
// Constants for the 10/100 line coder: timing, scrambler, framing
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH

// Clock rates and the MAC nibble clock
`define PLC_SYS_CLK_NS    50
`define PLC_MII_PERIOD_NS 400
`define PLC_MII_HALF_CYC  ((`PLC_MII_PERIOD_NS / 2) / `PLC_SYS_CLK_NS)

// Scrambler shape and seed
`define PLC_LFSR_W    11
`define PLC_TAP_HI    10
`define PLC_TAP_LO    8
`define PLC_SEED_FILL 6'h3F
`define PLC_ADDR_W    5

// Descrambler lock and end-of-frame idle run
`define PLC_LOCK_CNT 5'h10
`define PLC_IDLE_RUN 4'hA

// Data path shape
`define PLC_NIB_W      4
`define PLC_BYTE_BITS  4'h8
`define PLC_FIFO_DEPTH 4
`endif

// file: plc_pkg.sv
// Types shared by the line coder modules
package plc_pkg;
   typedef enum logic [1:0] {
      MLT_ZERO_UP,
      MLT_POS,
      MLT_ZERO_DN,
      MLT_NEG
   } plc_mlt_t;
   typedef logic [3:0] plc_nib_t;
   typedef logic [7:0] plc_byte_t;
endpackage

// file: plc_stream_if.sv
// Valid/ready stream carrier between the coder's own modules
`timescale 1ns/1ps
interface plc_stream_if #(parameter int W = 4);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// file: plc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`include "plc_params.svh"
module plc_fifo
   import plc_pkg::*;
#(
   parameter int W     = `PLC_NIB_W,
   parameter int DEPTH = `PLC_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill and drain sides
   plc_stream_if.snk in_s,
   plc_stream_if.src out_s
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [CW-1:0] cnt;
   logic          push;
   logic          pop;

   // Full and empty come straight from the fill count
   assign in_s.ready  = (cnt != CW'(DEPTH));
   assign out_s.valid = (cnt != '0);
   assign out_s.data  = mem[rp];
   assign push        = in_s.valid & in_s.ready;
   assign pop         = out_s.valid & out_s.ready;

   // Storage; no reset needed, valid gates every read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_s.data;
      end
   end

   // Pointers wrap explicitly so any depth works
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         if (push) begin
            wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
         end
         if (pop) begin
            rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
         end
         if (push && !pop) begin
            cnt <= cnt + 1'b1;
         end else if (pop && !push) begin
            cnt <= cnt - 1'b1;
         end
      end
   end
endmodule

// file: plc_top.sv
// 10/100 line coder: scrambler, NRZI, MLT-3, Manchester, MAC nibble side
`timescale 1ns/1ps
`include "plc_params.svh"
module plc_top
   import plc_pkg::*;
#(
   parameter int ADDR_W = `PLC_ADDR_W
) (
   // Clocks and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              line_clk,
   // Configuration
   input  wire logic              speed_100,
   input  wire logic              symbol_mode,
   input  wire logic [ADDR_W-1:0] phy_addr,
   // MAC transmit nibbles
   input  wire logic [3:0]        tx_nib,
   input  wire logic              tx_valid,
   output logic                   tx_ready,
   // MAC receive nibbles and clocking
   output logic [3:0]             rx_nib,
   output logic                   rx_valid,
   output logic                   mii_clk,
   output logic                   mii_10m,
   // Twisted-pair line
   output logic                   line_tx_pos,
   output logic                   line_tx_neg,
   input  wire logic              line_rx_pos,
   input  wire logic              line_rx_neg
);
   // ---------------- sys_clk domain signals
   plc_stream_if #(.W(`PLC_NIB_W)) f_in ();
   plc_stream_if #(.W(`PLC_NIB_W)) f_out ();
   plc_nib_t  plo;
   logic      phas_lo;
   plc_byte_t tx_word;
   logic      tx_req;
   logic      ack_s1;
   logic      ack_s2;
   logic      tx_busy;
   logic      rreq_s1;
   logic      rreq_s2;
   logic      r_ack;
   plc_nib_t  rx_hi;
   logic      hi_pend;
   logic [2:0] mdiv;

   // ---------------- line_clk domain signals
   logic              rs1;
   logic              line_rst_n;
   logic              spd_s1;
   logic              spd_l;
   logic              sym_s1;
   logic              sym_l;
   logic [ADDR_W-1:0] addr_s1;
   logic [ADDR_W-1:0] addr_l;
   logic [`PLC_LFSR_W-1:0] seed;
   logic              req_s1;
   logic              req_s2;
   logic              l_ack;
   logic              sh_full;
   plc_byte_t         sh;
   plc_byte_t         ser;
   logic [3:0]        cnt;
   logic              act;
   logic              half;
   logic              step;
   logic              cur_bit;
   logic              key;
   logic              scr_bit;
   logic [`PLC_LFSR_W-1:0] tx_lfsr;
   logic              nrzi;
   logic              nrzi_d;
   plc_mlt_t          mlt;
   plc_mlt_t          next_mlt;
   logic              rp_s1;
   logic              rp_l;
   logic              rn_s1;
   logic              rn_l;
   logic [1:0]        lvl_d;
   logic              r_nrzi;
   logic              r_nrzi_d;
   logic              nrz_bit;
   logic [`PLC_LFSR_W-1:0] d_lfsr;
   logic [4:0]        d_cnt;
   logic              d_lock;
   logic              dkey;
   logic              plain;
   logic              ok100;
   logic              r_act;
   logic [3:0]        run;
   logic              m_first;
   logic              m_half;
   logic              man_valid;
   logic              man_bit_ok;
   logic              bit_ok;
   logic              bit_val;
   logic              frame_on;
   plc_byte_t         a_sh;
   logic [3:0]        a_cnt;
   plc_byte_t         r_word;
   logic              r_tog;
   logic              rack_s1;
   logic              rack_s2;

   // MAC nibbles enter the FIFO; tx_ready is the FIFO's own back-pressure
   assign f_in.data  = tx_nib;
   assign f_in.valid = tx_valid;
   assign tx_ready   = f_in.ready;

   plc_fifo #(.W(`PLC_NIB_W), .DEPTH(`PLC_FIFO_DEPTH)) u_fifo (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .in_s  (f_in),
      .out_s (f_out)
   );

   // Pair nibbles into bytes so one crossing carries eight line bits
   assign tx_busy     = (tx_req != ack_s2);
   assign f_out.ready = !phas_lo || !tx_busy;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         plo     <= 4'h0;
         phas_lo <= 1'b0;
         tx_word <= 8'h00;
         tx_req  <= 1'b0;
      end else if (f_out.valid && f_out.ready) begin
         if (!phas_lo) begin
            plo     <= f_out.data;
            phas_lo <= 1'b1;
         end else begin
            tx_word <= {f_out.data, plo};
            tx_req  <= ~tx_req;
            phas_lo <= 1'b0;
         end
      end
   end

   // Bring line-side toggles back into sys_clk
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ack_s1  <= 1'b0;
         ack_s2  <= 1'b0;
         rreq_s1 <= 1'b0;
         rreq_s2 <= 1'b0;
      end else begin
         ack_s1  <= l_ack;
         ack_s2  <= ack_s1;
         rreq_s1 <= r_tog;
         rreq_s2 <= rreq_s1;
      end
   end

   // Received byte leaves as low nibble then high nibble
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_nib   <= 4'h0;
         rx_hi    <= 4'h0;
         rx_valid <= 1'b0;
         hi_pend  <= 1'b0;
         r_ack    <= 1'b0;
      end else if (rreq_s2 != r_ack) begin
         rx_nib   <= r_word[3:0];
         rx_hi    <= r_word[7:4];
         hi_pend  <= 1'b1;
         rx_valid <= 1'b1;
         r_ack    <= rreq_s2;
      end else if (hi_pend) begin
         rx_nib   <= rx_hi;
         rx_valid <= 1'b1;
         hi_pend  <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
      end
   end

   // 2.5 MHz nibble clock from sys_clk; 20 MHz cannot make 25 MHz, so 100M holds it low
   always_ff @(posedge sys_clk) begin
      if (!rst_n || speed_100) begin
         mdiv    <= 3'h0;
         mii_clk <= 1'b0;
      end else if (mdiv == 3'(`PLC_MII_HALF_CYC - 1)) begin
         mdiv    <= 3'h0;
         mii_clk <= ~mii_clk;
      end else begin
         mdiv <= mdiv + 3'h1;
      end
   end

   // MAC port flavour follows the speed
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mii_10m <= 1'b0;
      end else begin
         mii_10m <= ~speed_100;
      end
   end

   // ---------------- line_clk domain
   // Reset release, configuration, strap and handshake synchronisers
   always_ff @(posedge line_clk) begin
      rs1        <= rst_n;
      line_rst_n <= rs1;
      spd_s1     <= speed_100;
      spd_l      <= spd_s1;
      sym_s1     <= symbol_mode;
      sym_l      <= sym_s1;
      addr_s1    <= phy_addr;
      addr_l     <= addr_s1;
      req_s1     <= tx_req;
      req_s2     <= req_s1;
      rack_s1    <= r_ack;
      rack_s2    <= rack_s1;
      rp_s1      <= line_rx_pos;
      rp_l       <= rp_s1;
      rn_s1      <= line_rx_neg;
      rn_l       <= rn_s1;
   end

   assign seed    = {`PLC_SEED_FILL, addr_l};
   assign step    = spd_l | half;
   assign cur_bit = act ? ser[0] : 1'b1;
   assign key     = tx_lfsr[`PLC_TAP_HI] ^ tx_lfsr[`PLC_TAP_LO];
   assign scr_bit = sym_l ? cur_bit : (cur_bit ^ key);

   // Shadow byte plus serializer; a missing byte sends idle ones at 100M and leaves both line outputs low at 10M
   always_ff @(posedge line_clk) begin
      if (!line_rst_n) begin
         sh      <= 8'h00;
         sh_full <= 1'b0;
         l_ack   <= 1'b0;
         ser     <= 8'h00;
         cnt     <= 4'h0;
         act     <= 1'b0;
      end else begin
         if ((req_s2 != l_ack) && !sh_full) begin
            sh      <= tx_word;
            sh_full <= 1'b1;
            l_ack   <= req_s2;
         end
         if (step) begin
            if (cnt > 4'h1) begin
               ser <= {1'b0, ser[7:1]};
               cnt <= cnt - 4'h1;
            end else if (sh_full) begin
               ser     <= sh;
               cnt     <= `PLC_BYTE_BITS;
               act     <= 1'b1;
               sh_full <= 1'b0;
            end else begin
               cnt <= 4'h0;
               act <= 1'b0;
            end
         end
      end
   end

   // Manchester half-bit phase; 100M sends one bit per line clock
   always_ff @(posedge line_clk) begin
      if (!line_rst_n || spd_l) begin
         half <= 1'b0;
      end else begin
         half <= ~half;
      end
   end

   // Transmit keystream, seeded so neighbouring ports differ
   always_ff @(posedge line_clk) begin
      if (!line_rst_n) begin
         tx_lfsr <= seed;
      end else if (spd_l) begin
         tx_lfsr <= {tx_lfsr[`PLC_LFSR_W-2:0], key};
      end
   end

   // NRZI: a one toggles the level
   always_ff @(posedge line_clk) begin
      if (!line_rst_n) begin
         nrzi   <= 1'b0;
         nrzi_d <= 1'b0;
      end else if (spd_l) begin
         nrzi   <= nrzi ^ scr_bit;
         nrzi_d <= nrzi;
      end
   end

   // Three-level cycle order
   always_comb begin
      case (mlt)
         MLT_ZERO_UP: next_mlt = MLT_POS;
         MLT_POS:     next_mlt = MLT_ZERO_DN;
         MLT_ZERO_DN: next_mlt = MLT_NEG;
         MLT_NEG:     next_mlt = MLT_ZERO_UP;
         default:     next_mlt = MLT_ZERO_UP;
      endcase
   end

   // Step on each NRZI transition, hold otherwise
   always_ff @(posedge line_clk) begin
      if (!line_rst_n) begin
         mlt <= MLT_ZERO_UP;
      end else if (spd_l && (nrzi != nrzi_d)) begin
         mlt <= next_mlt;
      end
   end

   // Shared transmitter: three levels at 100M, two-level Manchester at 10M
   always_ff @(posedge line_clk) begin
      if (!line_rst_n) begin
         line_tx_pos <= 1'b0;
         line_tx_neg <= 1'b0;
      end else if (spd_l) begin
         line_tx_pos <= (mlt == MLT_POS);
         line_tx_neg <= (mlt == MLT_NEG);
      end else begin
         line_tx_pos <= act & (half ? ~ser[0] : ser[0]);
         line_tx_neg <= act & (half ? ser[0] : ~ser[0]);
      end
   end

   // Receive: level change is an NRZI toggle, NRZI change is a one
   assign nrz_bit = r_nrzi ^ r_nrzi_d;

   always_ff @(posedge line_clk) begin
      if (!line_rst_n) begin
         lvl_d    <= 2'h0;
         r_nrzi   <= 1'b0;
         r_nrzi_d <= 1'b0;
      end else begin
         lvl_d    <= {rp_l, rn_l};
         r_nrzi   <= r_nrzi ^ ({rp_l, rn_l} != lvl_d);
         r_nrzi_d <= r_nrzi;
      end
   end

   // Descrambler: idle is all ones, so cipher bits reveal the keystream
   assign dkey  = d_lfsr[`PLC_TAP_HI] ^ d_lfsr[`PLC_TAP_LO];
   assign plain = sym_l ? nrz_bit : (nrz_bit ^ dkey);
   assign ok100 = sym_l | d_lock;

   // Lock needs a long run of matching predictions; lock is kept until reset or a switch to 10M
   always_ff @(posedge line_clk) begin
      if (!line_rst_n || !spd_l) begin
         d_lfsr <= seed;
         d_cnt  <= 5'h00;
         d_lock <= 1'b0;
      end else if (!d_lock) begin
         d_lfsr <= {d_lfsr[`PLC_LFSR_W-2:0], ~nrz_bit};
         if (~nrz_bit == dkey) begin
            d_cnt <= d_cnt + 5'h01;
            if (d_cnt == (`PLC_LOCK_CNT - 5'h01)) begin
               d_lock <= 1'b1;
            end
         end else begin
            d_cnt <= 5'h00;
         end
      end else begin
         d_lfsr <= {d_lfsr[`PLC_LFSR_W-2:0], dkey};
      end
   end

   // 100M frame: opens on a plain zero, closes after a run of idle ones
   always_ff @(posedge line_clk) begin
      if (!line_rst_n || !spd_l || !ok100) begin
         r_act <= 1'b0;
         run   <= 4'h0;
      end else begin
         run <= plain ? run + 4'h1 : 4'h0;
         if (!plain) begin
            r_act <= 1'b1;
         end else if (run == (`PLC_IDLE_RUN - 4'h1)) begin
            r_act <= 1'b0;
         end
      end
   end

   // Manchester decode: no mid-bit transition means we are misaligned, so slip
   assign man_valid  = rp_l ^ rn_l;
   assign man_bit_ok = !spd_l && m_half && man_valid && (rp_l != m_first);

   always_ff @(posedge line_clk) begin
      if (!line_rst_n || spd_l || !man_valid) begin
         m_half  <= 1'b0;
         m_first <= 1'b0;
      end else if (!m_half || (rp_l == m_first)) begin
         m_first <= rp_l;
         m_half  <= 1'b1;
      end else begin
         m_half <= 1'b0;
      end
   end

   assign bit_ok   = spd_l ? (ok100 && (r_act || !plain)) : man_bit_ok;
   assign bit_val  = spd_l ? plain : m_first;
   assign frame_on = spd_l ? (ok100 && (r_act || !plain)) : man_valid;

   // Byte assembly, first bit in the low position; a byte that finds the
   // previous one still unacknowledged is dropped, as is a partial byte
   always_ff @(posedge line_clk) begin
      if (!line_rst_n) begin
         a_sh   <= 8'h00;
         a_cnt  <= 4'h0;
         r_word <= 8'h00;
         r_tog  <= 1'b0;
      end else if (!frame_on) begin
         a_cnt <= 4'h0;
      end else if (bit_ok) begin
         a_sh <= {bit_val, a_sh[7:1]};
         if (a_cnt == (`PLC_BYTE_BITS - 4'h1)) begin
            a_cnt <= 4'h0;
            if (r_tog == rack_s2) begin
               r_word <= {bit_val, a_sh[7:1]};
               r_tog  <= ~r_tog;
            end
         end else begin
            a_cnt <= a_cnt + 4'h1;
         end
      end
   end

   // ---------------- checks
   a_mlt_levels: assert property (@(posedge line_clk) disable iff (!line_rst_n)
      !(line_tx_pos && line_tx_neg)) else $error("both line levels driven");
   a_mlt_no_jump: assert property (@(posedge line_clk) disable iff (!line_rst_n)
      spd_l && $past(spd_l) |-> !(line_tx_pos && $past(line_tx_neg))
      && !(line_tx_neg && $past(line_tx_pos))) else $error("MLT-3 skipped zero");
   a_nrzi_one: assert property (@(posedge line_clk) disable iff (!line_rst_n)
      (spd_l && scr_bit) ##1 spd_l |=> (mlt != $past(mlt))) else $error("one did not step");
   a_nrzi_zero: assert property (@(posedge line_clk) disable iff (!line_rst_n)
      (spd_l && !scr_bit) ##1 spd_l |=> $stable(mlt)) else $error("zero moved level");
   a_manch_halves: assert property (@(posedge line_clk) disable iff (!line_rst_n)
      (!spd_l && $past(!spd_l) && act && half) |=> (line_tx_pos == !$past(line_tx_pos))
      && (line_tx_neg == !line_tx_pos)) else $error("no mid-bit flip");
   a_seed_load: assert property (@(posedge line_clk)
      !line_rst_n |=> (tx_lfsr == $past(seed))) else $error("scrambler not seeded");
   a_bypass_both: assert property (@(posedge line_clk) disable iff (!line_rst_n)
      sym_l |-> (scr_bit == cur_bit) && (plain == nrz_bit)) else $error("bypass broken");
   a_lfsr_live: assert property (@(posedge line_clk) disable iff (!line_rst_n)
      tx_lfsr != '0) else $error("scrambler stuck at zero");
   a_mii_clk_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(mii_clk) && !speed_100 |-> mii_clk[*4] ##1 !mii_clk) else $error("bad nibble clock");
   a_rx_pairs: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(rx_valid) |-> ##1 rx_valid ##1 !rx_valid) else $error("nibbles not paired");
   a_port_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
      speed_100 |=> !mii_10m && !mii_clk) else $error("port mode wrong");

   c_tx_100: cover property (@(posedge line_clk) disable iff (!line_rst_n) spd_l && act && !sym_l);
   c_tx_10: cover property (@(posedge line_clk) disable iff (!line_rst_n) !spd_l && act);
   c_lock: cover property (@(posedge line_clk) disable iff (!line_rst_n) $rose(d_lock));
   c_rx_nib: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(rx_valid));
endmodule

// file: plc_mac_model.sv
// MAC-side partner: sends queued nibbles and collects received ones
`timescale 1ns/1ps
module plc_mac_model
   import plc_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Transmit nibbles
   output plc_nib_t        tx_nib,
   output logic            tx_valid,
   input  wire logic       tx_ready,
   // Receive nibbles
   input  wire logic [3:0] rx_nib,
   input  wire logic       rx_valid
);
   plc_nib_t txq[$];
   plc_nib_t rxq[$];
   logic     full_seen;

   // Quiet at time zero
   initial begin
      tx_nib = 4'h0;
      tx_valid = 1'b0;
      full_seen = 1'b0;
   end

   // A nibble stands until taken; idle data toggles so stale values show
   always @(posedge sys_clk) begin
      if (rst_n && tx_valid && tx_ready)
         void'(txq.pop_front());
      if (tx_valid && !tx_ready)
         full_seen <= 1'b1;
      if (rst_n && rx_valid)
         rxq.push_back(rx_nib);
      tx_valid <= rst_n && (txq.size() > 0);
      tx_nib <= (txq.size() > 0) ? txq[0] : ~tx_nib;
   end
endmodule

// file: phy_line_coder_tx_rx_tb.sv
// Bench for the line coder: MAC model on the nibble side, line looped back
`timescale 1ns/1ps
module phy_line_coder_tx_rx_tb;
   import plc_pkg::*;
   logic       sys_clk, line_clk, rst_n, speed_100, symbol_mode;
   logic [4:0] phy_addr;
   plc_nib_t   tx_nib;
   logic       tx_valid, tx_ready, rx_valid, mii_clk, mii_10m, pos, neg;
   logic [3:0] rx_nib;
   logic [1:0] lq[$], qa[$];
   plc_nib_t   sent[$];
   int         errors, compares, k, n;

   // Line output fed straight back into the receiver
   plc_top u_plc_top (.sys_clk(sys_clk), .rst_n(rst_n), .line_clk(line_clk),
      .speed_100(speed_100), .symbol_mode(symbol_mode), .phy_addr(phy_addr),
      .tx_nib(tx_nib), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_nib(rx_nib),
      .rx_valid(rx_valid), .mii_clk(mii_clk), .mii_10m(mii_10m), .line_tx_pos(pos),
      .line_tx_neg(neg), .line_rx_pos(pos), .line_rx_neg(neg));
   plc_mac_model u_plc_mac_model (.sys_clk(sys_clk), .rst_n(rst_n), .tx_nib(tx_nib),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_nib(rx_nib), .rx_valid(rx_valid));

   // Clocks, phases unrelated
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      line_clk = 1'b0;
      #7;
      forever #15 line_clk = ~line_clk;
   end

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Counts both-high samples and, for three-level code, jumps across zero
   function automatic int bad(logic [1:0] q[$], bit mlt);
      bad = 0;
      for (int i = 1; i < q.size(); i++)
         bad += (q[i] == 2'b11) || (mlt && q[i-1] != 2'b00 && q[i-1] == ~q[i]);
   endfunction

   task automatic grab(int cnt);
      lq.delete();
      repeat (cnt) begin
         @(posedge line_clk);
         lq.push_back({pos, neg});
      end
   endtask

   // Mode pins only change under reset
   task automatic do_reset(logic s100, logic sym, logic [4:0] a);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      speed_100 <= s100;
      symbol_mode <= sym;
      phy_addr <= a;
      repeat (16) @(posedge sys_clk);
      check("reset_out", {pos, neg, rx_valid, mii_clk}, 4'h0);
      u_plc_mac_model.rxq.delete();
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      check("mii_10m", mii_10m, !s100);
   endtask

   // One zero byte looped at 100M; idle after it closes the frame with one all-ones byte
   task automatic loop_byte();
      plc_nib_t exp_q[$];
      exp_q = {4'h0, 4'h0, 4'hF, 4'hF};
      @(negedge sys_clk);
      u_plc_mac_model.rxq.delete();
      u_plc_mac_model.txq = {4'h0, 4'h0};
      n = 0;
      while (u_plc_mac_model.rxq.size() < 4 && n < 300) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 300) begin
         check("rx100_wait", 1'b0, 1'b1);
         stop_test();
      end
      repeat (20) @(posedge sys_clk);
      check("rx100_count", u_plc_mac_model.rxq.size(), 4);
      foreach (exp_q[i]) check("rx100_nib", u_plc_mac_model.rxq[i], exp_q[i]);
   endtask

   task automatic mii_check();
      logic [23:0] v;
      for (int i = 0; i < 24; i++) begin
         @(negedge sys_clk);
         v[i] = mii_clk;
      end
      k = 1;
      while (k < 12 && !(v[k] && !v[k-1]))
         k++;
      check("mii_clk_wave", v[k+:8], 8'h0F);
   endtask

   // Hang guard
   initial begin
      #3000000;
      check("watchdog", 1'b0, 1'b1);
      stop_test();
   end

   initial begin
      rst_n = 1'b0;
      speed_100 = 1'b0;
      symbol_mode = 1'b0;
      phy_addr = 5'h00;
      void'($urandom(32'hCFE02156));
      // 10M: corner nibbles first, then random, pushed faster than the line drains
      do_reset(1'b0, 1'b0, 5'($urandom));
      mii_check();
      sent = {4'h5, 4'hA};
      repeat (30) sent.push_back(4'($urandom));
      @(negedge sys_clk);
      u_plc_mac_model.txq = sent;
      grab(60);
      k = 0;
      while (k < 50 && lq[k] == 2'b00)
         k++;
      check("manch_first", {lq[k], lq[k+1], lq[k+2], lq[k+3]}, 8'h96);
      check("line_both", bad(lq, 1'b0), 0);
      n = 0;
      while (u_plc_mac_model.rxq.size() < 32 && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 3000) begin
         check("rx_wait", 1'b0, 1'b1);
         stop_test();
      end
      check("tx_refused", u_plc_mac_model.full_seen, 1'b1);
      foreach (sent[i]) check("rx_nib", u_plc_mac_model.rxq[i], sent[i]);
      $display("test manchester done");
      // 100M raw symbols: idle ones unscrambled step the level every bit
      do_reset(1'b1, 1'b1, 5'($urandom));
      grab(60);
      n = 0;
      k = 0;
      for (int i = 40; i < 59; i++) begin
         n += (lq[i] == lq[i+1]);
         k |= (lq[i] == 2'b10) | ((lq[i] == 2'b01) << 1);
      end
      check("sym_steps", n, 0);
      check("mlt_levels", k, 3);
      check("mii_clk_100", mii_clk, 1'b0);
      loop_byte();
      $display("test symbol done");
      // 100M scrambled idle from two station addresses
      do_reset(1'b1, 1'b0, 5'h03);
      grab(60);
      qa = lq;
      do_reset(1'b1, 1'b0, 5'h1C);
      grab(60);
      check("seed_differs", qa == lq, 1'b0);
      check("mlt_jump", bad(qa, 1'b1) + bad(lq, 1'b1), 0);
      n = 0;
      for (int i = 40; i < 59; i++)
         n += (qa[i] == qa[i+1]);
      check("scr_holds", n > 0, 1'b1);
      loop_byte();
      $display("test scrambler done");
      stop_test();
   end
endmodule
